// ==== include/apparent_energy_pkg.sv ====
// Operation
// - No offset correction is applied to the apparent power product itself.
// - Apparent power is added into a 49-bit accumulator on every step.
// - The total register shows bits 47 to 24 of the scaled accumulator.
// - One accumulation step happens every four master clock cycles.
// - Each addition into the accumulator is a signed addition.
// - Accumulator is divided by an unsigned 8-bit divider; zero means one.
// - A 24-bit read-to-clear energy register returns to zero on each read.
// - The energy register is unsigned for range, rollover and threshold events.
// - Half-full and overflow events are flagged and gated onto the interrupt.
// - Line energy accumulates only over whole half cycles from zero crossings.
// - Line accumulation always runs, with no mode bit.
// - An unsigned 16-bit count sets half cycles per line interval.
// - The line interval is shared with the active energy line accumulation.
// - Interval end sets the cycle-end flag and, if unmasked, pulls interrupt low.
// - Line energy uses the same data path and weight as the total register.
// - Apparent scaling differs from active: 0.848 at 50 Hz, 0.827 at 60 Hz.
// - Power is scaled by one plus a signed 12-bit trim over 4096 first.
`default_nettype none
package apparent_energy_pkg;
  localparam int ACC_W = 49;
  localparam int ENERGY_W = 24;
  localparam int ENERGY_LSB = 24;
  localparam int DIV_W = 8;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int COUNT_W = 16;
  localparam int PWR_W = 24;
  localparam int ADDR_W = 4;
  localparam int STEP_DIV = 4;
  localparam logic [1:0] STEP_LAST = 2'(STEP_DIV - 1);

  // Register indices on the register port
  localparam logic [3:0] ADDR_TOTAL = 4'h0;
  localparam logic [3:0] ADDR_DIVIDER = 4'h1;
  localparam logic [3:0] ADDR_READ_CLEAR = 4'h2;
  localparam logic [3:0] ADDR_HALF_CYCLES = 4'h3;
  localparam logic [3:0] ADDR_GAIN_TRIM = 4'h4;
  localparam logic [3:0] ADDR_LINE_ENERGY = 4'h5;

  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [15:0] HALF_CYCLES_RESET = 16'hFFFF;
  localparam logic [11:0] GAIN_RESET = 12'h000;

  // Status flag positions
  localparam int FLAG_HALF_FULL = 0;
  localparam int FLAG_OVERFLOW = 1;
  localparam int FLAG_CYCLE_END = 2;
  localparam int FLAG_N = 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [ENERGY_W-1:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// ==== hw/apparent_energy_accumulator.sv ====
`default_nettype none
module apparent_energy_accumulator #(
  parameter int ACC_WIDTH = 49,
  parameter int PWR_WIDTH = 24
) (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic signed [PWR_WIDTH-1:0] I_APPARENT_POWER,
  input wire logic I_ZERO_CROSS,
  input wire apparent_energy_pkg::reg_req_t I_REG_REQ,
  input wire logic [apparent_energy_pkg::FLAG_N-1:0] I_IRQ_MASK,
  input wire logic [apparent_energy_pkg::FLAG_N-1:0] I_STATUS_CLEAR,
  output logic [apparent_energy_pkg::ENERGY_W-1:0] O_REG_RDATA,
  output logic [apparent_energy_pkg::FLAG_N-1:0] O_STATUS,
  output logic O_LINE_INTERVAL_END,
  output logic O_IRQ_OUT,
  output logic O_IRQ_OE
);
  import apparent_energy_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (ACC_WIDTH != ACC_W) begin : g_acc_check
    $error("accumulator width must match the energy field layout");
  end
  if (PWR_WIDTH != PWR_W) begin : g_pwr_check
    $error("apparent power width not supported");
  end

  // ------------------------------------------------------------
  // Step enable
  // ------------------------------------------------------------
  logic [1:0] step_cnt_q;
  logic step;

  assign step = (step_cnt_q == STEP_LAST);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      step_cnt_q <= 2'h0;
    end else begin
      step_cnt_q <= step_cnt_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [DIV_W-1:0] divider_q;
  logic [COUNT_W-1:0] half_cycles_q;
  logic [GAIN_W-1:0] gain_q;
  logic [ENERGY_W-1:0] line_energy_q;
  logic wr_divider;
  logic wr_half_cycles;
  logic wr_gain;
  logic rd_clear;

  assign wr_divider = I_REG_REQ.wr && (I_REG_REQ.addr == ADDR_DIVIDER);
  assign wr_half_cycles = I_REG_REQ.wr && (I_REG_REQ.addr == ADDR_HALF_CYCLES);
  assign wr_gain = I_REG_REQ.wr && (I_REG_REQ.addr == ADDR_GAIN_TRIM);
  assign rd_clear = I_REG_REQ.rd && (I_REG_REQ.addr == ADDR_READ_CLEAR);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      divider_q <= DIVIDER_RESET;
      half_cycles_q <= HALF_CYCLES_RESET;
      gain_q <= GAIN_RESET;
    end else begin
      if (wr_divider) begin
        divider_q <= I_REG_REQ.wdata[DIV_W-1:0];
      end
      if (wr_half_cycles) begin
        half_cycles_q <= I_REG_REQ.wdata[COUNT_W-1:0];
      end
      if (wr_gain) begin
        gain_q <= I_REG_REQ.wdata[GAIN_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Gain trim
  // ------------------------------------------------------------
  logic signed [PWR_W+GAIN_W-1:0] trim_prod;
  logic signed [PWR_W:0] scaled_pwr;
  logic signed [ACC_W-1:0] step_add;

  // Raw product enters with no offset term; upstream rms trims cover it
  // Apparent weight differs from active by design of the upstream chain
  assign trim_prod = I_APPARENT_POWER * $signed(gain_q);
  assign scaled_pwr = (PWR_W + 1)'(I_APPARENT_POWER)
    + (PWR_W + 1)'(trim_prod >>> GAIN_SHIFT);
  assign step_add = ACC_W'(scaled_pwr);

  // ------------------------------------------------------------
  // Shared scaling path
  // ------------------------------------------------------------
  function automatic logic [ENERGY_W-1:0] energy_field(input logic [ACC_W-1:0] acc,
      input logic [DIV_W-1:0] div);
    logic [ACC_W-1:0] divisor;
    logic [ACC_W-1:0] quot;
    divisor = (div == '0) ? ACC_W'(1) : ACC_W'(div);
    quot = acc / divisor;
    energy_field = quot[ENERGY_LSB +: ENERGY_W];
  endfunction

  // ------------------------------------------------------------
  // Free-running total
  // ------------------------------------------------------------
  logic [ACC_W-1:0] total_acc_q;
  logic [ACC_W-1:0] total_acc_d;
  logic [ENERGY_W-1:0] total_now;
  logic [ENERGY_W-1:0] total_next;
  logic half_full_evt;
  logic overflow_evt;

  assign total_acc_d = total_acc_q + step_add;
  assign total_now = energy_field(total_acc_q, divider_q);
  assign total_next = energy_field(total_acc_d, divider_q);
  assign half_full_evt = step && !total_now[ENERGY_W-1] && total_next[ENERGY_W-1];
  assign overflow_evt = step && total_now[ENERGY_W-1] && !total_next[ENERGY_W-1]
    && !step_add[ACC_W-1];

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      total_acc_q <= '0;
    end else if (step) begin
      total_acc_q <= total_acc_d;
    end
  end

  // ------------------------------------------------------------
  // Read-to-clear copy
  // ------------------------------------------------------------
  logic [ACC_W-1:0] clear_acc_q;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      clear_acc_q <= '0;
    end else if (rd_clear) begin
      clear_acc_q <= step ? step_add : '0;
    end else if (step) begin
      clear_acc_q <= clear_acc_q + step_add;
    end
  end

  // ------------------------------------------------------------
  // Line interval
  // ------------------------------------------------------------
  logic [COUNT_W-1:0] zx_cnt_q;
  logic armed_q;
  logic [ACC_W-1:0] line_acc_q;
  logic interval_end;
  logic line_end_q;

  // Interval starts at a zero crossing and ends on the Nth crossing after it
  assign interval_end = armed_q && I_ZERO_CROSS && (half_cycles_q != '0)
    && (zx_cnt_q + 16'h0001 >= half_cycles_q);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || wr_half_cycles) begin
      zx_cnt_q <= '0;
      armed_q <= 1'b0;
    end else if (I_ZERO_CROSS) begin
      armed_q <= 1'b1;
      zx_cnt_q <= interval_end ? '0 : (armed_q ? zx_cnt_q + 16'h0001 : '0);
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || wr_half_cycles || !armed_q) begin
      line_acc_q <= '0;
    end else if (interval_end) begin
      line_acc_q <= step ? step_add : '0;
    end else if (step) begin
      line_acc_q <= line_acc_q + step_add;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      line_energy_q <= '0;
      line_end_q <= 1'b0;
    end else begin
      line_end_q <= interval_end;
      if (interval_end) begin
        line_energy_q <= energy_field(line_acc_q, divider_q);
      end
    end
  end

  assign O_LINE_INTERVAL_END = line_end_q;

  // ------------------------------------------------------------
  // Status and interrupt
  // ------------------------------------------------------------
  logic [FLAG_N-1:0] status_q;
  logic [FLAG_N-1:0] status_set;
  logic irq_q;

  always_comb begin
    status_set = '0;
    status_set[FLAG_HALF_FULL] = half_full_evt;
    status_set[FLAG_OVERFLOW] = overflow_evt;
    status_set[FLAG_CYCLE_END] = interval_end;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~I_STATUS_CLEAR) | status_set;
      irq_q <= |(((status_q & ~I_STATUS_CLEAR) | status_set) & I_IRQ_MASK);
    end
  end

  assign O_STATUS = status_q;
  assign O_IRQ_OUT = 1'b0;
  assign O_IRQ_OE = irq_q;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [ENERGY_W-1:0] rdata_sel;

  always_comb begin
    case (I_REG_REQ.addr)
      ADDR_TOTAL: rdata_sel = total_now;
      ADDR_DIVIDER: rdata_sel = ENERGY_W'(divider_q);
      ADDR_READ_CLEAR: rdata_sel = energy_field(clear_acc_q, divider_q);
      ADDR_HALF_CYCLES: rdata_sel = ENERGY_W'(half_cycles_q);
      ADDR_GAIN_TRIM: rdata_sel = ENERGY_W'(gain_q);
      ADDR_LINE_ENERGY: rdata_sel = line_energy_q;
      default: rdata_sel = '0;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_REG_RDATA <= '0;
    end else if (I_REG_REQ.rd) begin
      O_REG_RDATA <= rdata_sel;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/apparent_energy_chk.sv ====
`default_nettype none
module apparent_energy_chk #(
  parameter int PWR_WIDTH = 24
) (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic signed [PWR_WIDTH-1:0] I_APPARENT_POWER,
  input wire logic I_ZERO_CROSS,
  input wire apparent_energy_pkg::reg_req_t I_REG_REQ,
  input wire logic [2:0] I_IRQ_MASK,
  input wire logic [2:0] I_STATUS_CLEAR,
  input wire logic [23:0] O_REG_RDATA,
  input wire logic [2:0] O_STATUS,
  input wire logic O_LINE_INTERVAL_END,
  input wire logic O_IRQ_OUT,
  input wire logic O_IRQ_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  import apparent_energy_pkg::*;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  // ----
  // Port relations
  // ----
  irq_pin_low_a: assert property (O_IRQ_OUT == 1'b0)
    else $error("irq data level not low");
  irq_idle_a: assert property (O_STATUS == 3'h0 |-> !O_IRQ_OE)
    else $error("irq enable without a flag");
  irq_cycle_end_a: assert property (
    $rose(O_STATUS[2]) && I_IRQ_MASK[2] && $past(I_IRQ_MASK[2]) |-> O_IRQ_OE)
    else $error("unmasked cycle end left irq idle");
  line_end_cause_a: assert property (
    O_LINE_INTERVAL_END |-> $past(I_ZERO_CROSS) && O_STATUS[2])
    else $error("interval end without crossing or flag");
  cycle_end_cause_a: assert property ($rose(O_STATUS[2]) |-> $past(I_ZERO_CROSS))
    else $error("cycle end flag without crossing");
  flags_sticky_a: assert property (
    (($past(O_STATUS) & ~$past(I_STATUS_CLEAR)) & ~O_STATUS) == 3'h0)
    else $error("flag dropped without clear");
  cycle_clear_a: assert property (I_STATUS_CLEAR[2] && !I_ZERO_CROSS |=> !O_STATUS[2])
    else $error("cycle end flag not cleared");
  rdata_hold_a: assert property (!I_REG_REQ.rd |=> $stable(O_REG_RDATA))
    else $error("read data moved without a read");
  wrap_cause_a: assert property (
    $rose(O_STATUS[1]) |-> !$past(I_APPARENT_POWER[PWR_WIDTH-1]))
    else $error("overflow on a negative step");
endmodule
`default_nettype wire

// ==== testbench/apparent_energy_host.sv ====
`default_nettype none
module apparent_energy_host (
  input wire logic i_clk,
  input wire logic [23:0] i_rdata,
  output var apparent_energy_pkg::reg_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import apparent_energy_pkg::*;
  // ----
  // Register access
  // ----
  initial o_req = '0;
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_req.wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
    @(posedge i_clk);
    o_req.rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/apparent_energy_accumulator_bench.sv ====
`default_nettype none
module apparent_energy_accumulator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import apparent_energy_pkg::*;
  localparam logic signed [23:0] P = 24'sh400000;
  logic clk, srst, zc, lend, irq, oe;
  logic signed [23:0] pwr;
  reg_req_t req;
  logic [2:0] mask, clr, st;
  logic [23:0] rdata;
  int n_errors = 0;
  int n_tests = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  apparent_energy_accumulator i_dut(.I_CLOCK(clk), .I_SRST(srst), .I_APPARENT_POWER(pwr),
    .I_ZERO_CROSS(zc), .I_REG_REQ(req), .I_IRQ_MASK(mask), .I_STATUS_CLEAR(clr),
    .O_REG_RDATA(rdata), .O_STATUS(st), .O_LINE_INTERVAL_END(lend), .O_IRQ_OUT(irq),
    .O_IRQ_OE(oe));
  apparent_energy_host i_host(.i_clk(clk), .i_rdata(rdata), .o_req(req));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [23:0] e);
    logic [23:0] v;
    i_host.rd(a, v);
    chk(v, e);
  endtask
  task automatic run(input logic signed [23:0] p, input int n);
    pwr <= p;
    cyc(n);
    pwr <= 24'sh000000;
    cyc(8);
  endtask
  task automatic zx();
    zc <= 1'b1;
    @(posedge clk);
    zc <= 1'b0;
    cyc(2);
  endtask
  task automatic close_out();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  // ----
  // Sequence
  // ----
  initial begin
    srst = 1'b1;
    zc = 1'b0;
    pwr = 24'sh000000;
    mask = 3'h0;
    clr = 3'h0;
    cyc(20);
    srst <= 1'b0;
    cyc(1);
    rdc(ADDR_HALF_CYCLES, 24'h00FFFF);
    rdc(ADDR_DIVIDER, 24'h000000);
    rdc(4'h7, 24'h000000);
    i_host.wr(ADDR_TOTAL, 24'h123456);
    rdc(ADDR_TOTAL, 24'h000000);
    run(P, 64);
    rdc(ADDR_TOTAL, 24'h000004);
    rdc(ADDR_READ_CLEAR, 24'h000004);
    rdc(ADDR_READ_CLEAR, 24'h000000);
    i_host.wr(ADDR_DIVIDER, 24'h000002);
    rdc(ADDR_DIVIDER, 24'h000002);
    rdc(ADDR_TOTAL, 24'h000002);
    i_host.wr(ADDR_DIVIDER, 24'h000000);
    run(-P, 32);
    rdc(ADDR_TOTAL, 24'h000002);
    mask <= 3'b001;
    run(-P, 64);
    rdc(ADDR_TOTAL, 24'hFFFFFE);
    chk({20'h0, st, oe}, 24'h000003);
    clr <= 3'b001;
    cyc(1);
    clr <= 3'b000;
    cyc(1);
    chk({20'h0, st, oe}, 24'h000000);
    run(P, 96);
    rdc(ADDR_TOTAL, 24'h000004);
    chk({20'h0, st, oe}, 24'h000004);
    i_host.wr(ADDR_GAIN_TRIM, 24'h000800);
    rdc(ADDR_GAIN_TRIM, 24'h000800);
    run(P, 64);
    rdc(ADDR_TOTAL, 24'h000006);
    i_host.wr(ADDR_GAIN_TRIM, 24'h000000);
    clr <= 3'b111;
    mask <= 3'b100;
    cyc(1);
    clr <= 3'b000;
    i_host.wr(ADDR_HALF_CYCLES, 24'h000003);
    pwr <= P;
    repeat (3) begin
      zx();
      cyc(13);
    end
    zc <= 1'b1;
    @(posedge clk);
    zc <= 1'b0;
    pwr <= 24'sh000000;
    @(posedge clk);
    chk({21'h0, lend, st[2], oe}, 24'h000007);
    chk({23'h0, irq}, 24'h000000);
    rdc(ADDR_LINE_ENERGY, 24'h000003);
    close_out();
  end
endmodule
bind apparent_energy_accumulator apparent_energy_chk #(.PWR_WIDTH(PWR_WIDTH)) i_chk(.I_CLOCK,
  .I_SRST, .I_APPARENT_POWER, .I_ZERO_CROSS, .I_REG_REQ, .I_IRQ_MASK, .I_STATUS_CLEAR,
  .O_REG_RDATA, .O_STATUS, .O_LINE_INTERVAL_END, .O_IRQ_OUT, .O_IRQ_OE);
`default_nettype wire
